/* File: bia_pkg.sv */
package bia_pkg;
    // Request levels on the backplane
    localparam int unsigned NUM_LEVELS = 7;
    localparam int unsigned LEVEL_W    = 3;
    localparam int unsigned SYNC_DEPTH = 3;
    localparam int unsigned ID_W       = 8;
    localparam logic [ID_W-1:0] ID_RESET = 8'hff;

    // Interrupter chain stage states
    typedef enum logic [1:0]
    {
        BIA_IDLE = 2'b00,
        BIA_PASS = 2'b01,
        BIA_ANSW = 2'b10,
        BIA_DONE = 2'b11
    } bia_state_t;

    // Synchronised backplane inputs
    typedef struct packed
    {
        logic               iack_n;
        logic               iackin_n;
        logic               as_n;
        logic [LEVEL_W-1:0] addr;
    } bia_bus_t;
endpackage

/* File: bia_chain.sv */
`timescale 1ns/1ps
// Overview of operation
// - A pending request pulls the chosen active-low request line low.
// - The first-slot driver turns a low global acknowledge into a fall.
// - Only one interrupter on a shared line answers each acknowledge.
// - A requester answers only after a fall arrives at its chain input.
// - The answering stage holds its chain output high.
// - A non-matching or idle stage passes the fall downstream.
// - The acknowledged level is read from the three lowest address lines.
// - The answerer drives its identifier word, then data-acknowledge low.
module bia_chain
    import bia_pkg::*;
#(
    parameter logic [LEVEL_W-1:0] LEVEL    = 3'h1,
    parameter bit                 FIRST_SLOT = 1'b0
)
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    // Local side, on i_clk
    input  wire logic               i_req,
    input  wire logic [ID_W-1:0]    i_status_id,
    // Backplane lines, asynchronous to i_clk
    input  wire logic               i_iack_n,
    input  wire logic               i_iackin_n,
    input  wire logic               i_as_n,
    input  wire logic [LEVEL_W-1:0] i_addr,
    // Registered drivers; each _oe high turns its backplane driver on
    output logic                    o_irq_n_oe,
    output logic                    o_iackout_n,
    output logic [ID_W-1:0]         o_data,
    output logic                    o_data_oe,
    output logic                    o_dtack_n_oe,
    output logic                    o_acked
);

    // Synchroniser stages and the filtered bus view
    logic [SYNC_DEPTH-1:0] sync_iack_q;
    logic [SYNC_DEPTH-1:0] sync_in_q;
    logic [SYNC_DEPTH-1:0] sync_as_q;
    logic [LEVEL_W-1:0]    sync_a_q [SYNC_DEPTH];
    bia_bus_t              bus_q;
    // Chain edge detection
    logic                  chain_in;
    logic                  chain_prev_q;
    logic                  chain_fall;
    // Request and answer state
    logic                  pending_q;
    bia_state_t            state_q;
    logic                  data_ready_q;

    // Three-stage synchronisers; a change counts once stages 2 and 3 agree
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync_iack_q <= '1;
            sync_in_q   <= '1;
            sync_as_q   <= '1;
            for (int i = 0; i < SYNC_DEPTH; i++)
            begin
                sync_a_q[i] <= '0;
            end
        end
        else
        begin
            sync_iack_q <= {sync_iack_q[SYNC_DEPTH-2:0], i_iack_n};
            sync_in_q   <= {sync_in_q[SYNC_DEPTH-2:0], i_iackin_n};
            sync_as_q   <= {sync_as_q[SYNC_DEPTH-2:0], i_as_n};
            sync_a_q[0] <= i_addr;
            for (int i = 1; i < SYNC_DEPTH; i++)
            begin
                sync_a_q[i] <= sync_a_q[i-1];
            end
        end
    end

    // Agreement filter holds last stable value while stages disagree
    // Costs two cycles over a plain two-flop stage, but rejects a runt
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bus_q <= '{iack_n: 1'b1, iackin_n: 1'b1, as_n: 1'b1, addr: '0};
        end
        else
        begin
            if (sync_iack_q[1] == sync_iack_q[2])
                bus_q.iack_n <= sync_iack_q[2];
            if (sync_in_q[1] == sync_in_q[2])
                bus_q.iackin_n <= sync_in_q[2];
            if (sync_as_q[1] == sync_as_q[2])
                bus_q.as_n <= sync_as_q[2];
            if (sync_a_q[1] == sync_a_q[2])
                bus_q.addr <= sync_a_q[2];
        end
    end

    // First slot listens to the global acknowledge line instead
    assign chain_in   = FIRST_SLOT ? bus_q.iack_n : bus_q.iackin_n;
    assign chain_fall = chain_prev_q && !chain_in;

    // Last chain level; resets high like the idle line, so no false fall
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            chain_prev_q <= 1'b1;
        else
            chain_prev_q <= chain_in;
    end

    // Request latch; a new request wins over the clear of the old one
    // Only our own answer clears it; a passed cycle leaves it set
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pending_q <= 1'b0;
        else if (i_req)
            pending_q <= 1'b1;
        else if (state_q == BIA_DONE)
            pending_q <= 1'b0;
    end

    // Open-drain request pull-down
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_irq_n_oe <= 1'b0;
        else
            o_irq_n_oe <= pending_q && state_q != BIA_DONE;
    end

    // Chain stage: decide on the fall, hold a pass until input rises, an answer until input or AS rises
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_q <= BIA_IDLE;
        else
        begin
            case (state_q)
                BIA_IDLE:
                begin
                    // Decision only on the edge, never on a held low level
                    if (chain_fall)
                    begin
                        if (pending_q && bus_q.addr == LEVEL)
                            state_q <= BIA_ANSW;
                        else
                            state_q <= BIA_PASS;
                    end
                end
                BIA_PASS:
                begin
                    // Fall forwarded; follow the input back up
                    if (chain_in)
                        state_q <= BIA_IDLE;
                end
                BIA_ANSW:
                begin
                    // Word stays out until the handler lets go; AS high
                    // also ends it in case the chain input is still low
                    if (chain_in || bus_q.as_n)
                        state_q <= BIA_DONE;
                end
                BIA_DONE:
                begin
                    // One cycle in which the request is withdrawn
                    state_q <= BIA_IDLE;
                end
                default:
                begin
                    // Unused code; recover to idle
                    state_q <= BIA_IDLE;
                end
            endcase
        end
    end

    // Output only lowered while passing, so no glitch reaches downstream
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_iackout_n <= 1'b1;
        else
            o_iackout_n <= !(state_q == BIA_PASS && !chain_in);
    end

    // Data first, data-acknowledge two cycles later for set-up margin
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_data       <= ID_RESET;
            o_data_oe    <= 1'b0;
            data_ready_q <= 1'b0;
            o_dtack_n_oe <= 1'b0;
        end
        else
        begin
            // Word latched at the fall so it cannot change mid-cycle
            if (state_q == BIA_IDLE && chain_fall)
                o_data <= i_status_id;
            o_data_oe    <= state_q == BIA_ANSW;
            data_ready_q <= state_q == BIA_ANSW && o_data_oe;
            o_dtack_n_oe <= data_ready_q && state_q == BIA_ANSW;
        end
    end

    // One-cycle pulse when our acknowledge cycle finishes
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_acked <= 1'b0;
        else
            o_acked <= state_q == BIA_ANSW && (chain_in || bus_q.as_n);
    end

endmodule

/* File: bia_chain_props.sv */
`timescale 1ns/1ps
module bia_chain_props
    import bia_pkg::*;
#(
    parameter logic [LEVEL_W-1:0] LEVEL      = 3'h1,
    parameter bit                 FIRST_SLOT = 1'b0
)
(
    input wire logic         i_clk,
    input wire logic         i_rst_n,
    input wire logic         i_req,
    input wire logic         i_iack_n,
    input wire logic         i_iackin_n,
    input wire logic [2:0]   i_addr,
    input wire logic         o_irq_n_oe,
    input wire logic         o_iackout_n,
    input wire logic         o_data_oe,
    input wire logic         o_dtack_n_oe
);
    // Single domain, so clock and reset are set once
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_req_irq: assert property ($rose(i_req) |-> ##[1:3] o_irq_n_oe)
        else $error("irq late");
    a_no_early: assert property ($rose(o_data_oe) |->
        !i_iackin_n && $past(o_irq_n_oe)) else $error("early answer");
    a_answer_blocks: assert property (o_data_oe |-> o_iackout_n)
        else $error("fall leaked");
    a_dtack_order: assert property ($rose(o_dtack_n_oe) |->
        $past(o_data_oe, 2)) else $error("dtack before data");
    a_pass_only: assert property ($fell(o_iackout_n) |-> !i_iackin_n &&
        (i_addr != LEVEL || !o_irq_n_oe)) else $error("bad pass");
    a_match_answers: assert property ($fell(i_iackin_n) && o_irq_n_oe &&
        i_addr == LEVEL |-> ##[2:8] o_data_oe) else $error("no answer");
    a_idle_high: assert property (i_iackin_n [*6] |-> o_iackout_n)
        else $error("idle low");
    a_chain_release: assert property ($rose(i_iackin_n) |->
        ##[2:7] !o_data_oe && !o_dtack_n_oe && o_iackout_n)
        else $error("no release");
    a_slot_drive: assert property (FIRST_SLOT && $fell(i_iack_n) &&
        !o_irq_n_oe |-> ##[2:8] !o_iackout_n) else $error("no launch");
    c_answer: cover property ($rose(o_dtack_n_oe));
    c_pass: cover property ($fell(o_iackout_n));
    c_req: cover property ($rose(o_irq_n_oe));
    c_launch: cover property (FIRST_SLOT && $fell(o_iackout_n));
endmodule
bind bia_chain bia_chain_props #(.LEVEL(LEVEL), .FIRST_SLOT(FIRST_SLOT))
    u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_iack_n(i_iack_n), .i_iackin_n(i_iackin_n), .i_addr(i_addr),
    .o_irq_n_oe(o_irq_n_oe), .o_iackout_n(o_iackout_n),
    .o_data_oe(o_data_oe), .o_dtack_n_oe(o_dtack_n_oe));

/* File: bia_ih_model.sv */
`timescale 1ns/1ps
module bia_ih_model
    import bia_pkg::*;
#(
    parameter logic [NUM_LEVELS-1:0] SERVED = 7'h7f
)
(
    input  wire logic         i_clk,
    input  wire logic         i_dtack_n_oe,
    input  wire logic         i_iackout_n,
    input  wire logic [7:0]   i_data,
    output logic              o_as_n,
    output logic              o_iack_n,
    output logic [2:0]        o_addr
);
    // Idle bus before any cycle
    initial
    begin
        o_as_n = 1'b1;
        o_iack_n = 1'b1;
        o_addr = 3'h0;
    end
    // Highest requesting level among those this handler serves
    function automatic logic [LEVEL_W-1:0] pick(input logic [6:0] lines);
        logic [LEVEL_W-1:0] lv;
        lv = '0;
        for (int i = 1; i <= NUM_LEVELS; i++)
        begin
            if (lines[i-1] && SERVED[i-1])
                lv = LEVEL_W'(i);
        end
        return lv;
    endfunction
    // One acknowledge; hold sets a prompt or slow release
    task automatic ack(input logic [2:0] lvl, input int hold,
                       output logic ans, output logic pas,
                       output logic [7:0] id);
        int n;
        o_addr <= lvl;
        o_as_n <= 1'b0;
        @(posedge i_clk);
        o_iack_n <= 1'b0;
        n = 0;
        while (n < 20 && !i_dtack_n_oe && i_iackout_n)
        begin
            @(posedge i_clk);
            n++;
        end
        ans = i_dtack_n_oe;
        pas = !i_iackout_n;
        id = i_data;
        repeat (hold) @(posedge i_clk);
        o_iack_n <= 1'b1;
        o_as_n <= 1'b1;
        o_addr <= ~lvl; // Released lines must not keep the old level
        // Release must ripple through the slot-one stage as well
        repeat (12) @(posedge i_clk);
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import bia_pkg::*;
    localparam logic [2:0] LVL = 3'h5;
    logic       i_clk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0, pend, ans, pas;
    logic       irq, iout, doe, dtk, as_n, iin, rq, iak, acked;
    logic [2:0] addr, lvl;
    logic [6:0] lines;
    logic [7:0] n_ack = 8'h00, n_ans = 8'h00;
    logic [7:0] sid = 8'h00, dat, got;
    logic [15:0] lf = 16'h002f;
    int         bad_count = 0, n_checks = 0;
    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;
    // Slot-one driver turns the global acknowledge into the chain fall
    bia_chain #(.FIRST_SLOT(1'b1)) uut_slot1 (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_req(1'b0), .i_status_id(8'h00),
        .i_iack_n(iak), .i_iackin_n(iak), .i_as_n(as_n), .i_addr(addr),
        .o_irq_n_oe(), .o_iackout_n(iin), .o_data(), .o_data_oe(),
        .o_dtack_n_oe(), .o_acked());
    bia_chain #(.LEVEL(LVL)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_req(i_req), .i_status_id(sid), .i_iack_n(iak),
        .i_iackin_n(iin), .i_as_n(as_n), .i_addr(addr), .o_irq_n_oe(irq),
        .o_iackout_n(iout), .o_data(dat), .o_data_oe(doe),
        .o_dtack_n_oe(dtk), .o_acked(acked));
    bia_ih_model h (.i_clk(i_clk), .i_dtack_n_oe(dtk), .i_iackout_n(iout),
        .i_data(dat), .o_as_n(as_n), .o_iack_n(iak), .o_addr(addr));
    // Completion pulses seen from the answering stage
    always @(posedge i_clk)
    begin
        if (acked)
            n_ack <= n_ack + 8'h01;
    end
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog: 40 tests of about 35 to 45 cycles each, with wide margin
    initial
    begin
        #200000;
        bad_count++;
        report_and_stop;
    end
    // First four tests are fixed corners, then random levels and requests
    initial
    begin
        pend = 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 40; k++)
        begin
            lf = nxt(lf);
            rq = k == 1 || k == 2 || (k > 3 && lf[3]);
            @(posedge i_clk);
            i_req <= rq;
            sid <= lf[15:8];
            @(posedge i_clk);
            i_req <= 1'b0;
            pend = pend | rq;
            lines = k == 2 ? 7'h02 : (k < 4 ? 7'h10 : lf[12:6] | 7'h01);
            if (pend && k > 3)
                lines[LVL-1] = 1'b1;
            lvl = h.pick(lines);
            repeat (3) @(posedge i_clk);
            chk(irq, pend);
            h.ack(lvl, lf[5:4] == 2'b11 ? 12 : 2, ans, pas, got);
            chk({ans, pas}, pend && lvl == LVL ? 2'b10 : 2'b01);
            if (ans)
                chk(got, lf[15:8]);
            chk(iout, 1'b1);
            if (pend && lvl == LVL)
                n_ans = n_ans + 8'h01;
            chk(n_ack, n_ans);
            pend = pend && lvl != LVL;
            $display("test %0d done", k);
        end
        report_and_stop;
    end
endmodule
